//--- rtl/cls_pkg.sv
// Constants, types and carriers for the configuration load and init sequencer.
// Assumes a 10 MHz reference clock; all times are converted to cycles here.
package cls_pkg;

   // Reference clock
   localparam int unsigned CLK_PERIOD_NS     = 100;

   // Power-on-reset hold of the status pin
   localparam int unsigned POR_DELAY_US      = 200;
   localparam int unsigned POR_CYC           = (POR_DELAY_US * 1000) / CLK_PERIOD_NS;
   // Status held low after a frame check failure before an automatic restart
   localparam int unsigned ERR_HOLD_US       = 10;
   localparam int unsigned ERR_HOLD_CYC      = (ERR_HOLD_US * 1000) / CLK_PERIOD_NS;
   // Done high to initialization clock enable
   localparam int unsigned DONE_TO_CLK_EN_US = 10;
   localparam int unsigned DONE_TO_CLK_EN_CYC =
      (DONE_TO_CLK_EN_US * 1000) / CLK_PERIOD_NS;
   // Least time from flash select low to first flash clock toggle
   localparam int unsigned FLASH_SETUP_NS    = 15;
   localparam int unsigned FLASH_SETUP_RAW   =
      (FLASH_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FLASH_SETUP_CYC   = (FLASH_SETUP_RAW < 1) ? 1 : FLASH_SETUP_RAW;
   // Initialization clock cycles needed before user mode
   localparam int unsigned INIT_CYCLE_COUNT  = 1024;

   localparam int unsigned CNT_W             = 16;

   // Self-clocked serial flash: half period of the generated clock in ref cycles
   localparam logic [3:0] FLASH_HALF_CYC     = 4'h4;

   // Stream framing: data words per frame, then one check word
   localparam logic [7:0]  FRAME_WORDS       = 8'h08;
   localparam logic [7:0]  FRAME_COUNT       = 8'h04;
   localparam logic [31:0] CRC_POLY          = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT          = 32'hffffffff;

   // Register port
   localparam int unsigned ADDR_W            = 4;
   localparam int unsigned DATA_W            = 8;
   localparam logic [3:0]  REG_CTRL          = 4'h0;
   localparam logic [3:0]  REG_STATUS        = 4'h1;
   localparam logic [7:0]  CTRL_RESET        = 8'h00;
   // Status register field positions
   localparam int unsigned STAT_ERR_BIT      = 7;
   localparam int unsigned STAT_USER_BIT     = 6;
   localparam int unsigned STAT_DONE_BIT     = 5;

   // Configuration scheme and initialization clock source codes
   localparam logic [1:0] MODE_PASSIVE_SERIAL = 2'h0;
   localparam logic [1:0] MODE_FAST_PARALLEL  = 2'h1;
   localparam logic [1:0] MODE_ACTIVE_SERIAL  = 2'h2;
   localparam logic [1:0] INIT_SRC_OSC        = 2'h0;
   localparam logic [1:0] INIT_SRC_USER       = 2'h1;
   localparam logic [1:0] INIT_SRC_CFGCLK     = 2'h2;

   typedef enum logic [2:0] {
      ST_POR,
      ST_RESET,
      ST_CONFIG,
      ST_ERROR,
      ST_DONE_WAIT,
      ST_INIT,
      ST_USER
   } cls_state_type;

   // Control register layout, msb first
   typedef struct packed {
      logic       spare;
      logic       wide;          // 16-bit parallel or 4-bit flash data
      logic [1:0] mode;
      logic       init_done_en;
      logic [1:0] init_src;
      logic       auto_restart;
   } cls_ctrl_type;

   // Pin inputs after filtering
   localparam int unsigned PIN_W = 26;
   typedef struct packed {
      logic        cfg_clk;
      logic        request_n;
      logic        status_n;
      logic        complete;
      logic        user_clk;
      logic [15:0] data;
      logic        serial;
      logic [3:0]  flash;
   } cls_pins_type;

endpackage

//--- rtl/cls_sync3.sv
// Three-stage pin input filter; output moves only when stages two and three agree.
// Assumes inputs are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module cls_sync3 #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] filt_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               s1_r[g]   <= 1'b0;
               s2_r[g]   <= 1'b0;
               s3_r[g]   <= 1'b0;
               filt_o[g] <= 1'b0;
            end else begin
               s1_r[g] <= pin_i[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  filt_o[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

endmodule

//--- rtl/cls_frame_crc.sv
// Frame checker: runs a 32-bit check over each frame of data words and
// compares it with the check word that follows the frame.
// Assumes words arrive as one-cycle strobes on the reference clock.
`timescale 1ns/1ps
module cls_frame_crc (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        clear_i,
   input  wire logic        word_vld_i,
   input  wire logic [31:0] word_i,
   output logic             crc_err_o,
   output logic             stream_done_o
);

   logic [31:0] crc_r;
   logic [7:0]  word_idx_r;
   logic [7:0]  frame_idx_r;

   function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] w);
      logic [31:0] c;
      logic        fb;
      c  = crc;
      fb = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         fb = c[31] ^ w[i];
         c  = {c[30:0], 1'b0} ^ (fb ? cls_pkg::CRC_POLY : 32'h00000000);
      end
      return c;
   endfunction

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         crc_r         <= cls_pkg::CRC_INIT;
         word_idx_r    <= 8'h00;
         frame_idx_r   <= 8'h00;
         crc_err_o     <= 1'b0;
         stream_done_o <= 1'b0;
      end else begin
         crc_err_o     <= 1'b0;
         stream_done_o <= 1'b0;
         if (clear_i) begin
            crc_r       <= cls_pkg::CRC_INIT;
            word_idx_r  <= 8'h00;
            frame_idx_r <= 8'h00;
         end else if (word_vld_i) begin
            if (word_idx_r == cls_pkg::FRAME_WORDS) begin
               word_idx_r <= 8'h00;
               crc_r      <= cls_pkg::CRC_INIT;
               if (word_i != crc_r) begin
                  crc_err_o <= 1'b1;
               end else if (frame_idx_r == cls_pkg::FRAME_COUNT - 8'h01) begin
                  stream_done_o <= 1'b1;
                  frame_idx_r   <= 8'h00;
               end else begin
                  frame_idx_r <= frame_idx_r + 8'h01;
               end
            end else begin
               crc_r      <= crc_step(crc_r, word_i);
               word_idx_r <= word_idx_r + 8'h01;
            end
         end
      end
   end

endmodule

//--- rtl/cls_sequencer.sv
// Configuration load, error restart, initialization and user-mode entry sequencer.
// Assumes raw pins arrive asynchronously; open-drain pins resolved outside.
`timescale 1ns/1ps
module cls_sequencer #(
   parameter int unsigned POR_CYCLES = cls_pkg::POR_CYC
) (
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_b_i,
   // Register port
   input  wire logic [cls_pkg::ADDR_W-1:0]  reg_addr_i,
   input  wire logic [cls_pkg::DATA_W-1:0]  reg_wdata_i,
   input  wire logic                        reg_wr_i,
   input  wire logic                        reg_rd_i,
   output logic      [cls_pkg::DATA_W-1:0]  reg_rdata_o,
   // Configuration pins
   input  wire logic                        config_request_n_i,
   input  wire logic                        config_clock_i,
   output logic                             config_clock_o,
   output logic                             config_clock_oe_o,
   input  wire logic [15:0]                 config_data_i,
   input  wire logic                        serial_data_i,
   input  wire logic [3:0]                  serial_flash_data_i,
   output logic                             flash_select_n_o,
   input  wire logic                        user_init_clock_i,
   input  wire logic                        config_status_n_i,
   output logic                             config_status_n_o,
   output logic                             config_status_n_oe_o,
   input  wire logic                        config_complete_i,
   output logic                             config_complete_o,
   output logic                             config_complete_oe_o,
   output logic                             init_complete_out_o,
   output logic                             init_complete_out_oe_o,
   output logic                             core_init_complete_o
);

   cls_pkg::cls_pins_type  pins;
   cls_pkg::cls_ctrl_type  ctrl_r;
   cls_pkg::cls_state_type state_r;
   cls_pkg::cls_state_type state_nxt;

   logic [cls_pkg::CNT_W-1:0] cnt_r;
   logic [cls_pkg::CNT_W-1:0] cnt_nxt;
   logic        cfg_clk_d_r;
   logic        user_clk_d_r;
   logic        err_flag_r;
   logic        status_seen_r;
   logic [3:0]  fdiv_r;
   logic [31:0] asm_word_r;
   logic [5:0]  asm_bits_r;
   logic        word_vld_r;
   logic        crc_err;
   logic        stream_done;
   logic        asm_clear;
   logic        cfg_rise;
   logic        cfg_fall;
   logic        user_rise;
   logic        flash_sample;
   logic        chunk_take;
   logic        init_tick;
   logic        is_flash;
   logic [15:0] chunk;
   logic [5:0]  chunk_w;

   cls_sync3 #(
      .W (cls_pkg::PIN_W)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .pin_i     ({config_clock_i, config_request_n_i, config_status_n_i,
                   config_complete_i, user_init_clock_i, config_data_i,
                   serial_data_i, serial_flash_data_i}),
      .filt_o    (pins)
   );

   assign is_flash  = (ctrl_r.mode == cls_pkg::MODE_ACTIVE_SERIAL);
   assign cfg_rise  = pins.cfg_clk & ~cfg_clk_d_r;
   assign cfg_fall  = ~pins.cfg_clk & cfg_clk_d_r;
   assign user_rise = pins.user_clk & ~user_clk_d_r;
   assign flash_sample = (state_r == cls_pkg::ST_CONFIG) && is_flash &&
                         (cnt_r == '0) && (fdiv_r == 2 * cls_pkg::FLASH_HALF_CYC - 4'h1);
   // Passive data only counts while configuring; later edges are ignored
   assign chunk_take = (state_r == cls_pkg::ST_CONFIG) &&
                       (is_flash ? flash_sample : cfg_rise);
   assign asm_clear  = (state_nxt == cls_pkg::ST_CONFIG) && (state_r != cls_pkg::ST_CONFIG);

   // Bits per capture by scheme and width
   always_comb begin
      chunk   = 16'h0000;
      chunk_w = 6'h01;
      unique case (ctrl_r.mode)
         cls_pkg::MODE_FAST_PARALLEL: begin
            chunk   = ctrl_r.wide ? pins.data : {8'h00, pins.data[7:0]};
            chunk_w = ctrl_r.wide ? 6'h10 : 6'h08;
         end
         cls_pkg::MODE_ACTIVE_SERIAL: begin
            chunk   = ctrl_r.wide ? {12'h000, pins.flash} : {15'h0000, pins.flash[0]};
            chunk_w = ctrl_r.wide ? 6'h04 : 6'h01;
         end
         default: begin
            chunk   = {15'h0000, pins.serial};
            chunk_w = 6'h01;
         end
      endcase
   end

   // Word assembly, least significant bits first
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         asm_word_r <= 32'h00000000;
         asm_bits_r <= 6'h00;
         word_vld_r <= 1'b0;
      end else begin
         word_vld_r <= 1'b0;
         if (asm_clear) begin
            asm_bits_r <= 6'h00;
         end else if (chunk_take) begin
            unique case (chunk_w)
               6'h10:   asm_word_r <= {chunk, asm_word_r[31:16]};
               6'h08:   asm_word_r <= {chunk[7:0], asm_word_r[31:8]};
               6'h04:   asm_word_r <= {chunk[3:0], asm_word_r[31:4]};
               default: asm_word_r <= {chunk[0], asm_word_r[31:1]};
            endcase
            if (asm_bits_r + chunk_w == 6'h20) begin
               asm_bits_r <= 6'h00;
               word_vld_r <= 1'b1;
            end else begin
               asm_bits_r <= asm_bits_r + chunk_w;
            end
         end
      end
   end

   cls_frame_crc u_crc (
      .ref_clk_i     (ref_clk_i),
      .rst_b_i       (rst_b_i),
      .clear_i       (asm_clear),
      .word_vld_i    (word_vld_r),
      .word_i        (asm_word_r),
      .crc_err_o     (crc_err),
      .stream_done_o (stream_done)
   );

   // Initialization clock source selection
   always_comb begin
      unique case (ctrl_r.init_src)
         cls_pkg::INIT_SRC_USER:   init_tick = user_rise;
         cls_pkg::INIT_SRC_CFGCLK: init_tick = is_flash ? 1'b1 : cfg_fall;
         default:                  init_tick = 1'b1;
      endcase
   end

   // Sequence control
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
      unique case (state_r)
         cls_pkg::ST_POR: begin
            if (cnt_r == '0) begin
               state_nxt = cls_pkg::ST_RESET;
            end
         end
         cls_pkg::ST_RESET: begin
            if (pins.request_n) begin
               state_nxt = cls_pkg::ST_CONFIG;
               cnt_nxt   = cls_pkg::CNT_W'(cls_pkg::FLASH_SETUP_CYC);
            end
         end
         cls_pkg::ST_CONFIG: begin
            if (crc_err || (status_seen_r && !pins.status_n)) begin
               state_nxt = cls_pkg::ST_ERROR;
               cnt_nxt   = cls_pkg::CNT_W'(cls_pkg::ERR_HOLD_CYC);
            end else if (stream_done) begin
               state_nxt = cls_pkg::ST_DONE_WAIT;
               cnt_nxt   = cls_pkg::CNT_W'(cls_pkg::DONE_TO_CLK_EN_CYC);
            end
         end
         cls_pkg::ST_ERROR: begin
            if (cnt_r == '0 && ctrl_r.auto_restart) begin
               state_nxt = cls_pkg::ST_CONFIG;
               cnt_nxt   = cls_pkg::CNT_W'(cls_pkg::FLASH_SETUP_CYC);
            end
         end
         cls_pkg::ST_DONE_WAIT: begin
            if (cnt_r == '0 && pins.complete) begin
               state_nxt = cls_pkg::ST_INIT;
               cnt_nxt   = cls_pkg::CNT_W'(cls_pkg::INIT_CYCLE_COUNT);
            end
         end
         cls_pkg::ST_INIT: begin
            cnt_nxt = cnt_r;
            if (init_tick) begin
               if (cnt_r == cls_pkg::CNT_W'(1)) begin
                  state_nxt = cls_pkg::ST_USER;
               end
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         cls_pkg::ST_USER: begin
         end
      endcase
      // Request low restarts from anywhere after power-on
      if (state_r != cls_pkg::ST_POR && !pins.request_n) begin
         state_nxt = cls_pkg::ST_RESET;
         cnt_nxt   = '0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r      <= cls_pkg::ST_POR;
         cnt_r        <= cls_pkg::CNT_W'(POR_CYCLES);
         cfg_clk_d_r  <= 1'b0;
         user_clk_d_r <= 1'b0;
         status_seen_r <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         cnt_r        <= cnt_nxt;
         // Our own low drive lingers in the filter; only a low after a high is outside
         status_seen_r <= (state_r == cls_pkg::ST_CONFIG) && (status_seen_r || pins.status_n);
         cfg_clk_d_r  <= pins.cfg_clk;
         user_clk_d_r <= pins.user_clk;
      end
   end

   // Pin drive from the next state so they change with the state; init complete enable follows the control bit
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         config_status_n_o      <= 1'b0;
         config_status_n_oe_o   <= 1'b1;
         config_complete_o      <= 1'b0;
         config_complete_oe_o   <= 1'b1;
         init_complete_out_o    <= 1'b0;
         init_complete_out_oe_o <= 1'b0;
         core_init_complete_o   <= 1'b0;
      end else begin
         config_status_n_o    <= 1'b0;
         // Status low in power-on, reset and error
         config_status_n_oe_o <= (state_nxt == cls_pkg::ST_POR) ||
                                 (state_nxt == cls_pkg::ST_RESET) ||
                                 (state_nxt == cls_pkg::ST_ERROR);
         config_complete_o    <= 1'b0;
         // Complete held low until the stream checks clean
         config_complete_oe_o <= (state_nxt == cls_pkg::ST_POR) ||
                                 (state_nxt == cls_pkg::ST_RESET) ||
                                 (state_nxt == cls_pkg::ST_CONFIG) ||
                                 (state_nxt == cls_pkg::ST_ERROR);
         // Init complete driven low once enabled, high in user mode
         init_complete_out_oe_o <= ctrl_r.init_done_en;
         init_complete_out_o    <= ctrl_r.init_done_en && (state_nxt == cls_pkg::ST_USER);
         core_init_complete_o   <= (state_nxt == cls_pkg::ST_USER);
      end
   end

   // Serial flash select and self-generated clock
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flash_select_n_o  <= 1'b1;
         config_clock_o    <= 1'b0;
         config_clock_oe_o <= 1'b0;
         fdiv_r            <= 4'h0;
      end else begin
         flash_select_n_o  <= !(is_flash && state_nxt == cls_pkg::ST_CONFIG);
         config_clock_oe_o <= is_flash;
         if (state_r == cls_pkg::ST_CONFIG && is_flash && cnt_r == '0) begin
            // First toggle only after select setup has elapsed
            fdiv_r         <= (fdiv_r == 2 * cls_pkg::FLASH_HALF_CYC - 4'h1) ? 4'h0 :
                              fdiv_r + 4'h1;
            config_clock_o <= (fdiv_r >= cls_pkg::FLASH_HALF_CYC - 4'h1) &&
                              (fdiv_r != 2 * cls_pkg::FLASH_HALF_CYC - 4'h1);
         end else begin
            fdiv_r         <= 4'h0;
            config_clock_o <= 1'b0;
         end
      end
   end

   // Register port
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r <= cls_pkg::CTRL_RESET;
      end else if (reg_wr_i && reg_addr_i == cls_pkg::REG_CTRL) begin
         ctrl_r <= reg_wdata_i;
      end
   end

   // Sticky error; a new error wins over a clear in the same cycle
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         err_flag_r <= 1'b0;
      end else if (crc_err) begin
         err_flag_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == cls_pkg::REG_STATUS &&
                   reg_wdata_i[cls_pkg::STAT_ERR_BIT]) begin
         err_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i && reg_addr_i == cls_pkg::REG_CTRL) begin
         reg_rdata_o <= ctrl_r;
      end else if (reg_rd_i && reg_addr_i == cls_pkg::REG_STATUS) begin
         reg_rdata_o <= {err_flag_r, (state_r == cls_pkg::ST_USER),
                         pins.complete, 2'b00, state_r};
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule

//--- sim/cls_sequencer_assertions.sv
// Checker on the sequencer pins.
// Assumes it is bound to cls_sequencer and sees its ports only.
`timescale 1ns/1ps
module cls_sequencer_assertions #(
   parameter int unsigned POR_CYCLES = 20
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic config_request_n_i,
   input wire logic config_status_n_oe_o,
   input wire logic config_complete_oe_o,
   input wire logic init_complete_out_o,
   input wire logic init_complete_out_oe_o,
   input wire logic core_init_complete_o
);
   logic [15:0] por_cnt_r;
   logic [15:0] rel_cnt_r;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) por_cnt_r <= 16'h0;
      else if (por_cnt_r < 16'(POR_CYCLES)) por_cnt_r <= por_cnt_r + 16'h1;
   end
   // Cycles since the done pin was let go
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) rel_cnt_r <= 16'h0;
      else if (config_complete_oe_o) rel_cnt_r <= 16'h0;
      else if (rel_cnt_r != 16'hffff) rel_cnt_r <= rel_cnt_r + 16'h1;
   end
   sequence s_req_drop;
      $fell(config_request_n_i) ##1 !config_request_n_i [*3];
   endsequence
   AST_POR_HOLD: assert property (por_cnt_r < 16'(POR_CYCLES) |-> config_status_n_oe_o)
      else $error("status released early");
   AST_DONE_WITH_STATUS: assert property
      (config_status_n_oe_o && $past(config_status_n_oe_o) |-> config_complete_oe_o)
      else $error("done released while status low");
   AST_DONE_CLEAN: assert property ($fell(config_complete_oe_o) |->
      !config_status_n_oe_o && !$past(config_status_n_oe_o)) else $error("done after error");
   AST_INIT_LENGTH: assert property ($rose(core_init_complete_o) |-> rel_cnt_r >=
      16'(cls_pkg::DONE_TO_CLK_EN_CYC + cls_pkg::INIT_CYCLE_COUNT)) else $error("init short");
   AST_INIT_GATED: assert property (init_complete_out_o |-> core_init_complete_o)
      else $error("init pin high early");
   AST_INIT_RAISE: assert property
      ($rose(core_init_complete_o) && init_complete_out_oe_o |-> ##[0:1] init_complete_out_o)
      else $error("init pin not raised");
   AST_USER_PINS: assert property
      (core_init_complete_o |-> !config_status_n_oe_o && !config_complete_oe_o)
      else $error("pins low in user mode");
   AST_REQ_RESTART: assert property
      (core_init_complete_o ##0 s_req_drop |-> ##[0:8] config_status_n_oe_o)
      else $error("no restart on request");
endmodule

bind cls_sequencer cls_sequencer_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .config_request_n_i(config_request_n_i),
   .config_status_n_oe_o(config_status_n_oe_o), .config_complete_oe_o(config_complete_oe_o),
   .init_complete_out_o(init_complete_out_o), .init_complete_out_oe_o(init_complete_out_oe_o),
   .core_init_complete_o(core_init_complete_o));

//--- sim/cls_host_model.sv
// Configuration host: 800 ns link clock and 16-bit parallel data.
// Assumes send() is called only once the status pin is released.
`timescale 1ns/1ps
module cls_host_model (
   output logic        cfg_clk_o,
   output logic [15:0] data_o
);
   initial begin
      cfg_clk_o = 1'b0;
      data_o    = 16'h0000;
   end
   function automatic logic [31:0] crc_w(input logic [31:0] c, input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? cls_pkg::CRC_POLY : 32'h0);
      end
      return c;
   endfunction
   // Clock idles low; data is set before each rise
   task automatic edge_out(input logic [15:0] v);
      data_o = v;
      #400 cfg_clk_o = 1'b1;
      #400 cfg_clk_o = 1'b0;
   endtask
   task automatic send(input int frames, input logic bad);
      logic [31:0] c;
      logic [31:0] w;
      for (int f = 0; f < frames; f++) begin
         c = cls_pkg::CRC_INIT;
         for (int k = 0; k <= int'(cls_pkg::FRAME_WORDS); k++) begin
            w = 32'h9e3779b9 * (f * 16 + k + 1);
            if (k < int'(cls_pkg::FRAME_WORDS)) c = crc_w(c, w);
            else w = c ^ {31'h0, bad};
            edge_out(w[15:0]);
            edge_out(w[31:16]);
         end
      end
      edge_out(~data_o);
      edge_out(~data_o);
      data_o = ~data_o;
   endtask
endmodule

//--- sim/cls_sequencer_tb.sv
// Bench for cls_sequencer: register tasks and a parallel configuration host.
// Assumes a 10 MHz clock and a shortened power-on hold.
`timescale 1ns/1ps
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("unexpected %0t %s", $time, m); end end
module cls_sequencer_tb;
   localparam int unsigned POR = 20;
   logic        clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0, req_n = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00, rdata, d;
   logic        ck_o, ck_oe, st_oe, cc_oe, ic, ic_oe, core, fs_n, st_o, cc_o, uclk = 1'b0;
   wire         host_clk;
   wire  [15:0] host_data;
   int          fails = 0, num_checks = 0;
   always #50 clk = ~clk;
   // Free-running user initialization clock, 800 ns period
   always #400 uclk = ~uclk;
   cls_host_model host (.cfg_clk_o(host_clk), .data_o(host_data));
   cls_sequencer #(.POR_CYCLES(POR)) DUT (.ref_clk_i(clk), .rst_b_i(rst_b),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
      .reg_rdata_o(rdata), .config_request_n_i(req_n),
      .config_clock_i(ck_oe ? ck_o : host_clk), .config_clock_o(ck_o),
      .config_clock_oe_o(ck_oe), .config_data_i(host_data), .serial_data_i(1'b0),
      .serial_flash_data_i(4'h0), .flash_select_n_o(fs_n), .user_init_clock_i(uclk),
      .config_status_n_i(!st_oe), .config_status_n_o(st_o), .config_status_n_oe_o(st_oe),
      .config_complete_i(!cc_oe), .config_complete_o(cc_o), .config_complete_oe_o(cc_oe),
      .init_complete_out_o(ic), .init_complete_out_oe_o(ic_oe), .core_init_complete_o(core));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic req(input int n);
      @(posedge clk);
      req_n <= 1'b0;
      cyc(n);
      @(posedge clk);
      req_n <= 1'b1;
      cyc(1);
   endtask
   task automatic give_verdict();
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #2000000;
      fails++;
      give_verdict();
   end
   initial begin
      cyc(16);
      rst_b <= 1'b1;
      cyc(1);
      `CHK(st_oe, 1'b1, "por hold")
      `CHK(cc_oe, 1'b1, "done low")
      cyc(POR + 10);
      `CHK(st_oe, 1'b0, "status release")
      rd(cls_pkg::REG_CTRL);
      `CHK(d, cls_pkg::CTRL_RESET, "ctrl reset")
      rd(4'h9);
      `CHK(d, 8'h00, "unmapped")
      wr(cls_pkg::REG_CTRL, 8'h58);
      rd(cls_pkg::REG_CTRL);
      `CHK(d, 8'h58, "ctrl write")
      host.send(1, 1'b1);
      cyc(10);
      `CHK(st_oe, 1'b1, "check error")
      rd(cls_pkg::REG_STATUS);
      `CHK(d[7], 1'b1, "error flag")
      `CHK(d[2:0], 3'h3, "error state")
      cyc(cls_pkg::ERR_HOLD_CYC + 20);
      `CHK(st_oe, 1'b1, "error held")
      req(10);
      cyc(10);
      `CHK(st_oe, 1'b0, "restart by request")
      wr(cls_pkg::REG_STATUS, 8'h80);
      rd(cls_pkg::REG_STATUS);
      `CHK(d[7], 1'b0, "error clear")
      wr(cls_pkg::REG_CTRL, 8'h59);
      host.send(1, 1'b1);
      cyc(10);
      `CHK(st_oe, 1'b1, "check error")
      cyc(cls_pkg::ERR_HOLD_CYC + 10);
      `CHK(st_oe, 1'b0, "auto restart")
      rd(cls_pkg::REG_STATUS);
      `CHK(d[2:0], 3'h2, "reloading")
      host.send(int'(cls_pkg::FRAME_COUNT), 1'b0);
      cyc(4);
      `CHK(cc_oe, 1'b0, "done released")
      `CHK(core, 1'b0, "init too soon")
      for (int i = 0; i < 1500 && core !== 1'b1; i++) cyc(1);
      `CHK(core, 1'b1, "user mode")
      `CHK(ic, 1'b1, "init pin")
      `CHK(ic_oe, 1'b1, "init pin enable")
      rd(cls_pkg::REG_STATUS);
      `CHK(d[6:5], 2'h3, "user and done")
      `CHK(d[2:0], 3'h6, "user state")
      host.send(1, 1'b0);
      `CHK(core, 1'b1, "clock ignored")
      req(8);
      `CHK(st_oe, 1'b1, "reconfig status")
      `CHK(cc_oe, 1'b1, "reconfig done")
      `CHK(core, 1'b0, "left user mode")
      `CHK({fs_n, st_o, cc_o}, 3'b100, "pin levels")
      wr(cls_pkg::REG_CTRL, 8'h5a);
      cyc(10);
      host.send(int'(cls_pkg::FRAME_COUNT), 1'b0);
      cyc(1300);
      `CHK(core, 1'b0, "user clock init")
      req(4);
      `CHK(st_oe, 1'b1, "restart in init")
      cyc(10);
      `CHK(st_oe, 1'b0, "status back high")
      host.send(int'(cls_pkg::FRAME_COUNT), 1'b0);
      for (int i = 0; i < 9000 && core !== 1'b1; i++) cyc(1);
      `CHK(core, 1'b1, "user clock init done")
      give_verdict();
   end
endmodule
